/* temp_limit_consts.svh */
// Purpose: Offsets, field positions and reset values of the limit registers.
// Assumes: A 3-bit register address as carried by the serial command byte.
// Notes:   Definitions only.
`ifndef TEMP_LIMIT_CONSTS_SVH
`define TEMP_LIMIT_CONSTS_SVH

// ****************************************
// Register offsets
// ****************************************
`define ADDR_TEMP 3'h2
`define ADDR_IDENT 3'h3
`define ADDR_CRIT 3'h4
`define ADDR_HYST 3'h5
`define ADDR_HIGH 3'h6
`define ADDR_LOW 3'h7

// ****************************************
// Reset values
// ****************************************
`define RST_TEMP 16'h0000
`define RST_CRIT 16'h4980
`define RST_HYST 8'h05
`define RST_HIGH 16'h2000
`define RST_LOW 16'h0500

// ****************************************
// Field positions
// ****************************************
`define TEMP_SIGN_BIT 15
`define FLAG_CRIT_BIT 2
`define FLAG_HIGH_BIT 1
`define FLAG_LOW_BIT 0
`define HYST_MSB 3
`define HYST_SCALE 7

`endif

/* temp_limit_pkg.sv */
// Purpose: Types shared by the limit register bank and its front end.
// Assumes: Register strobes and conversion results arrive on CLK.
// Notes:   Offsets and reset values live in temp_limit_consts.svh.
package temp_limit_pkg;

  // Register access from the serial front end, one cycle strobes.
  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [2:0] addr;
    logic [15:0] wdata;
  } reg_req_t;

  // One finished conversion: done is a one-cycle pulse.
  typedef struct packed
  {
    logic done;
    logic [15:0] value;
  } conv_t;

  // Per-limit comparison results.
  typedef struct packed
  {
    logic crit;
    logic high;
    logic low;
  } limit_evt_t;

endpackage : temp_limit_pkg

/* fault_counter.sv */
// Purpose: Counts consecutive faulty conversions for one limit.
// Assumes: sample is a one-cycle pulse per conversion.
// Notes:   qualified is combinational and valid only while sample is high.
`timescale 1ns/1ps
module fault_counter
(
  input wire logic clk,
  input wire logic rst,
  input wire logic sample,
  input wire logic fault,
  input wire logic [1:0] depth,
  output logic qualified
);

  logic [1:0] count_reg;
  logic [1:0] count_next;
  wire logic count_full = (count_reg == 2'h3);

  // Code 00 needs one fault, code 11 needs four in a row.
  assign qualified = sample && fault && (count_reg >= depth);
  assign count_next = !sample ? count_reg :
                      !fault ? 2'h0 :
                      count_full ? count_reg : count_reg + 2'h1;

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      count_reg <= 2'h0;
    else
      count_reg <= count_next;
  end

  a_queue_restart:
    assert property (@(posedge clk) disable iff (rst)
      sample && !fault |=> count_reg == 2'h0)
    else $error("fault count not cleared by a good conversion");

  a_queue_first:
    assert property (@(posedge clk) disable iff (rst)
      sample && fault && count_reg == 2'h0 && depth != 2'h0 |-> !qualified)
    else $error("alarm qualified before the fault queue filled");

endmodule : fault_counter

/* temp_limit_compare_regs.sv */
// Purpose: Temperature word, identification and limit registers with
//          critical and limit alarm generation.
// Assumes: Register strobes come from the serial front end on CLK;
//          conversion results come from the converter on CLK.
// Notes:   Alarm outputs are active-high logic levels; pin polarity and
//          open-drain drive are handled outside this block.
`timescale 1ns/1ps
`include "temp_limit_consts.svh"

// Functional notes
// - Critical limit at 0x04, flag temp above it.
// - Critical event asserts the critical alarm output.
// - Limits and temperature compared as signed.
// - Critical limit resets to 0x4980.
// - Temperature word read-only, sign bit 15, resets zero.
// - Bit 2: critical flag or magnitude bit.
// - Bit 1: upper flag or magnitude bit.
// - Bit 0: lower flag or magnitude bit.
// - Identification byte: maker code and revision.
// - Hysteresis at 0x05, low nibble 0-15 degrees.
// - Hysteresis releases alarms below or above limits.
// - Hysteresis resets to 0101, upper nibble zero.
// - Upper limit at 0x06, flag temp above.
// - Over or under event asserts limit alarm.
// - Upper limit resets to 0x2000.
// - Lower limit at 0x07, flag temp below.
// - Lower limit resets to 0x0500.
// - Resolution selects 13-bit or 16-bit word.
// - Alarm only after queued consecutive faults.
// - Interrupt mode: register read clears limit alarm.
module temp_limit_compare_regs
  import temp_limit_pkg::*;
#(
  parameter logic [4:0] MAKER_CODE = 5'h0a,   // Arbitrary value.
  parameter logic [2:0] REVISION_CODE = 3'h1  // Arbitrary value.
)
(
  input wire logic CLK,
  input wire logic RST,
  input wire reg_req_t REG_REQ,
  output logic [15:0] REG_RDATA,
  input wire conv_t CONV,
  input wire logic RES_16BIT,
  input wire logic COMPARATOR_MODE,
  input wire logic [1:0] FAULT_QUEUE,
  output logic CRIT_ALARM,
  output logic LIMIT_ALARM
);

  // ****************************************
  // Register storage
  // ****************************************
  logic [15:0] temp_reg;
  logic [15:0] temp_next;
  logic [15:0] crit_reg;
  logic [15:0] crit_next;
  logic [15:0] high_reg;
  logic [15:0] high_next;
  logic [15:0] low_reg;
  logic [15:0] low_next;
  logic [7:0] hyst_reg;
  logic [7:0] hyst_next;
  logic [15:0] rdata_next;

  wire logic wr_crit = REG_REQ.wr && (REG_REQ.addr == `ADDR_CRIT);
  wire logic wr_hyst = REG_REQ.wr && (REG_REQ.addr == `ADDR_HYST);
  wire logic wr_high = REG_REQ.wr && (REG_REQ.addr == `ADDR_HIGH);
  wire logic wr_low = REG_REQ.wr && (REG_REQ.addr == `ADDR_LOW);

  assign crit_next = wr_crit ? REG_REQ.wdata : crit_reg;
  assign hyst_next = wr_hyst ? REG_REQ.wdata[7:0] : hyst_reg;
  assign high_next = wr_high ? REG_REQ.wdata : high_reg;
  assign low_next = wr_low ? REG_REQ.wdata : low_reg;

  // ****************************************
  // Signed comparison against the limits
  // ****************************************
  // In 13-bit mode the three low bits of the result are not temperature,
  // so they are cleared before comparing and replaced by the three flags when stored.
  wire logic [15:0] conv_word =
    RES_16BIT ? CONV.value : {CONV.value[15:3], 3'h0};

  // One extra bit keeps limit minus and plus hysteresis from wrapping.
  wire logic signed [16:0] t_s =
    {conv_word[`TEMP_SIGN_BIT], conv_word};
  wire logic signed [16:0] crit_s = {crit_reg[`TEMP_SIGN_BIT], crit_reg};
  wire logic signed [16:0] high_s = {high_reg[`TEMP_SIGN_BIT], high_reg};
  wire logic signed [16:0] low_s = {low_reg[`TEMP_SIGN_BIT], low_reg};

  // One degree is 128 counts of the temperature word in both resolutions.
  wire logic signed [16:0] hyst_s =
    {6'h00, hyst_reg[`HYST_MSB:0], 7'h00};

  wire logic signed [16:0] crit_rel = crit_s - hyst_s;
  wire logic signed [16:0] high_rel = high_s - hyst_s;
  wire logic signed [16:0] low_rel = low_s + hyst_s;

  limit_evt_t raw;
  limit_evt_t clr;

  assign raw.crit = t_s > crit_s;
  assign raw.high = t_s > high_s;
  assign raw.low = t_s < low_s;
  assign clr.crit = t_s < crit_rel;
  assign clr.high = t_s < high_rel;
  assign clr.low = t_s > low_rel;

  // ****************************************
  // Temperature word
  // ****************************************
  // Writes to the temperature word are ignored.
  // Bit 2 is the critical, bit 1 the upper and bit 0 the lower flag.
  wire logic [2:0] flag_bits =
    {raw.crit, raw.high, raw.low};
  assign temp_next = !CONV.done ? temp_reg :
                     RES_16BIT ? CONV.value :
                     {CONV.value[15:3], flag_bits};

  // ****************************************
  // Event state per limit with fault queue
  // ****************************************
  // Index 2 is the critical limit, 1 the upper, 0 the lower.
  wire logic [2:0] fault_vec = raw;
  wire logic [2:0] clr_vec = clr;
  logic [2:0] qual_vec;
  logic [2:0] state_reg;
  logic [2:0] state_next;
  wire logic [2:0] rise_vec = state_next & ~state_reg;

  genvar i;
  generate
    for (i = 0; i < 3; i++)
    begin : g_limit
      fault_counter u_queue
      (
        .clk(CLK),
        .rst(RST),
        .sample(CONV.done),
        .fault(fault_vec[i]),
        .depth(FAULT_QUEUE),
        .qualified(qual_vec[i])
      );

      // An active event ends only once the hysteresis band is left.
      assign state_next[i] = !CONV.done ? state_reg[i] :
                             state_reg[i] ? !clr_vec[i] :
                             qual_vec[i];
    end
  endgenerate

  // ****************************************
  // Alarm outputs
  // ****************************************
  // A new event in the same cycle as a read wins over the clear.
  logic int_pend_reg;
  wire logic limit_rise = rise_vec[1] || rise_vec[0];
  wire logic int_pend_next = limit_rise ? 1'b1 :
                             REG_REQ.rd ? 1'b0 : int_pend_reg;
  wire logic limit_next = COMPARATOR_MODE ? (state_next[1] || state_next[0])
                                          : int_pend_next;
  wire logic crit_alarm_next = state_next[2];

  // ****************************************
  // Read data
  // ****************************************
  wire logic [15:0] ident_word =
    {8'h00, MAKER_CODE, REVISION_CODE};
  wire logic [15:0] read_sel =
    (REG_REQ.addr == `ADDR_TEMP) ? temp_reg :
    (REG_REQ.addr == `ADDR_IDENT) ? ident_word :
    (REG_REQ.addr == `ADDR_CRIT) ? crit_reg :
    (REG_REQ.addr == `ADDR_HYST) ? {8'h00, hyst_reg} :
    (REG_REQ.addr == `ADDR_HIGH) ? high_reg :
    (REG_REQ.addr == `ADDR_LOW) ? low_reg : 16'h0000;
  assign rdata_next = REG_REQ.rd ? read_sel : REG_RDATA;

  // ****************************************
  // Flip-flops
  // ****************************************
  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      temp_reg <= `RST_TEMP;
      crit_reg <= `RST_CRIT;
      hyst_reg <= `RST_HYST;
      high_reg <= `RST_HIGH;
      low_reg <= `RST_LOW;
    end
    else
    begin
      temp_reg <= temp_next;
      crit_reg <= crit_next;
      hyst_reg <= hyst_next;
      high_reg <= high_next;
      low_reg <= low_next;
    end
  end

  always_ff @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= 3'h0;
      int_pend_reg <= 1'b0;
      CRIT_ALARM <= 1'b0;
      LIMIT_ALARM <= 1'b0;
      REG_RDATA <= 16'h0000;
    end
    else
    begin
      state_reg <= state_next;
      int_pend_reg <= int_pend_next;
      CRIT_ALARM <= crit_alarm_next;
      LIMIT_ALARM <= limit_next;
      REG_RDATA <= rdata_next;
    end
  end

  // ****************************************
  // Assertions
  // ****************************************
  sequence s_reset_release;
    $past(RST) && !RST;
  endsequence

  sequence s_crit_fault_now;
    CONV.done && raw.crit && FAULT_QUEUE == 2'h0;
  endsequence

  sequence s_crit_stays;
    CONV.done && !clr.crit;
  endsequence

  a_limits_reset:
    assert property (@(posedge CLK) disable iff (RST)
      s_reset_release |-> crit_reg == 16'h4980 && high_reg == 16'h2000
        && low_reg == 16'h0500)
    else $error("limit registers not at their reset values");

  a_hyst_reset:
    assert property (@(posedge CLK) disable iff (RST)
      s_reset_release |-> hyst_reg == 8'h05 && temp_reg == 16'h0000)
    else $error("hysteresis or temperature word reset value wrong");

  a_crit_write:
    assert property (@(posedge CLK) disable iff (RST)
      REG_REQ.wr && REG_REQ.addr == 3'h4 |=> crit_reg == $past(REG_REQ.wdata))
    else $error("critical limit write not stored");

  a_temp_readonly:
    assert property (@(posedge CLK) disable iff (RST)
      REG_REQ.wr && REG_REQ.addr == 3'h2 && !CONV.done |=> $stable(temp_reg))
    else $error("temperature word changed by a register write");

  a_crit_flag:
    assert property (@(posedge CLK) disable iff (RST)
      CONV.done && !RES_16BIT |=> temp_reg[2] ==
        ($signed({$past(CONV.value[15:3]), 3'h0}) > $signed($past(crit_reg))))
    else $error("critical flag bit wrong in 13-bit mode");

  a_high_flag:
    assert property (@(posedge CLK) disable iff (RST)
      CONV.done && !RES_16BIT |=> temp_reg[1] ==
        ($signed({$past(CONV.value[15:3]), 3'h0}) > $signed($past(high_reg))))
    else $error("upper flag bit wrong in 13-bit mode");

  a_low_flag:
    assert property (@(posedge CLK) disable iff (RST)
      CONV.done && !RES_16BIT |=> temp_reg[0] ==
        ($signed({$past(CONV.value[15:3]), 3'h0}) < $signed($past(low_reg))))
    else $error("lower flag bit wrong in 13-bit mode");

  a_full_word:
    assert property (@(posedge CLK) disable iff (RST)
      CONV.done && RES_16BIT |=> temp_reg == $past(CONV.value))
    else $error("16-bit result not stored whole");

  a_signed_low:
    assert property (@(posedge CLK) disable iff (RST)
      CONV.done && CONV.value[15] && !low_reg[15] |-> raw.low)
    else $error("negative temperature not below a positive limit");

  a_crit_alarm:
    assert property (@(posedge CLK) disable iff (RST)
      s_crit_fault_now |=> CRIT_ALARM)
    else $error("critical alarm missing after a critical event");

  a_crit_hold:
    assert property (@(posedge CLK) disable iff (RST)
      CRIT_ALARM ##0 s_crit_stays |=> CRIT_ALARM)
    else $error("critical alarm dropped inside the hysteresis band");

  a_limit_alarm:
    assert property (@(posedge CLK) disable iff (RST)
      COMPARATOR_MODE && CONV.done && (raw.high || raw.low)
        && FAULT_QUEUE == 2'h0 |=> LIMIT_ALARM)
    else $error("limit alarm missing after a limit event");

  a_read_clears:
    assert property (@(posedge CLK) disable iff (RST)
      !COMPARATOR_MODE && REG_REQ.rd && !CONV.done |=> !LIMIT_ALARM)
    else $error("register read did not clear the limit alarm");

  a_ident_read:
    assert property (@(posedge CLK) disable iff (RST)
      REG_REQ.rd && REG_REQ.addr == 3'h3 |=>
        REG_RDATA == {8'h00, MAKER_CODE, REVISION_CODE})
    else $error("identification byte read wrong");

  a_hyst_write:
    assert property (@(posedge CLK) disable iff (RST)
      REG_REQ.wr && REG_REQ.addr == 3'h5 |=>
        hyst_reg == $past(REG_REQ.wdata[7:0]))
    else $error("hysteresis write not stored");

  a_high_write:
    assert property (@(posedge CLK) disable iff (RST)
      REG_REQ.wr && REG_REQ.addr == 3'h6 |=> high_reg == $past(REG_REQ.wdata))
    else $error("upper limit write not stored");

  a_low_write:
    assert property (@(posedge CLK) disable iff (RST)
      REG_REQ.wr && REG_REQ.addr == 3'h7 |=> low_reg == $past(REG_REQ.wdata))
    else $error("lower limit write not stored");

  a_state_frozen:
    assert property (@(posedge CLK) disable iff (RST)
      !CONV.done |=> $stable(state_reg) && $stable(CRIT_ALARM))
    else $error("event state changed without a conversion");

  a_crit_release:
    assert property (@(posedge CLK) disable iff (RST)
      CONV.done && clr.crit |=> !CRIT_ALARM)
    else $error("critical alarm held below the hysteresis band");

  a_alarms_reset:
    assert property (@(posedge CLK) disable iff (RST)
      s_reset_release |-> !CRIT_ALARM && !LIMIT_ALARM
        && REG_RDATA == 16'h0000)
    else $error("outputs not cleared by reset");

  a_int_set:
    assert property (@(posedge CLK) disable iff (RST)
      !COMPARATOR_MODE && CONV.done && (raw.high || raw.low)
        && FAULT_QUEUE == 2'h0 && state_reg[1:0] == 2'h0 |=> LIMIT_ALARM)
    else $error("new limit event did not raise the limit alarm");

endmodule : temp_limit_compare_regs

/* host_model.sv */
// Purpose: Serial bus master seen as one-cycle register strobes.
// Assumes: Strobes are launched and released on the falling clock edge.
// Notes:   Released address and data lines show the inverse of last value.
`timescale 1ns/1ps
module host_model
  import temp_limit_pkg::*;
(
  input wire logic clk,
  input wire logic [15:0] rdata,
  output reg_req_t req
);
  initial
  begin
    req = '0;
  end

  task automatic put(input logic r, input logic w, input logic [2:0] a,
                     input logic [15:0] d);
    @(negedge clk);
    req.rd = r;
    req.wr = w;
    req.addr = a;
    req.wdata = d;
    @(negedge clk);
    req.rd = 1'b0;
    req.wr = 1'b0;
    req.addr = ~a;
    req.wdata = ~d;
  endtask : put

  task automatic reg_write(input logic [2:0] a, input logic [15:0] d);
    put(1'b0, 1'b1, a, d);
  endtask : reg_write

  // Read data is taken one edge after the strobe.
  task automatic reg_read(input logic [2:0] a, output logic [15:0] d);
    put(1'b1, 1'b0, a, 16'h0000);
    d = rdata;
  endtask : reg_read
endmodule : host_model

/* tb.sv */
// Purpose: Self-checking bench for the limit register bank.
// Assumes: Comparator mode unless a test selects interrupt mode.
// Notes:   Hysteresis of 5 degrees shifts release points by 16'h0280.
`timescale 1ns/1ps
`include "temp_limit_consts.svh"
module tb
  import temp_limit_pkg::*;
;
  localparam logic [4:0] MAKER = 5'h15;  // Arbitrary value.
  localparam logic [2:0] REV = 3'h2;     // Arbitrary value.
  logic clk;
  logic rst;
  reg_req_t req;
  logic [15:0] rdata;
  conv_t conv_in;
  logic res16;
  logic cmp_mode;
  logic [1:0] fq;
  logic crit;
  logic lim;
  int n_errors;
  int total_checks;

  temp_limit_compare_regs #(.MAKER_CODE(MAKER), .REVISION_CODE(REV)) dut_u
  (
    .CLK(clk), .RST(rst), .REG_REQ(req), .REG_RDATA(rdata), .CONV(conv_in),
    .RES_16BIT(res16), .COMPARATOR_MODE(cmp_mode), .FAULT_QUEUE(fq),
    .CRIT_ALARM(crit), .LIMIT_ALARM(lim)
  );
  host_model host_u (.clk(clk), .rdata(rdata), .req(req));

  // ****************************************
  // Checking helpers
  // ****************************************
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic rd_chk(input string name, input logic [2:0] a,
                        input logic [15:0] exp);
    logic [15:0] d;
    host_u.reg_read(a, d);
    check(name, d, exp);
  endtask : rd_chk

  // Feeds one conversion, then checks both alarms after its answer edge.
  task automatic conv(input logic [15:0] v, input logic c, input logic l);
    @(negedge clk);
    conv_in = {1'b1, v};
    @(negedge clk);
    conv_in = {1'b0, ~v};
    check("crit_alarm", {15'h0, crit}, {15'h0, c});
    check("limit_alarm", {15'h0, lim}, {15'h0, l});
  endtask : conv

  task automatic end_of_test;
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : end_of_test

  // ****************************************
  // Clock, reset and watchdog
  // ****************************************
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    $display("[ERR] watchdog expected end seen hang");
    end_of_test;
  end

  // ****************************************
  // Tests
  // ****************************************
  initial
  begin
    n_errors = 0;
    total_checks = 0;
    rst = 1'b1;
    conv_in = '0;
    res16 = 1'b0;
    cmp_mode = 1'b1;
    fq = 2'h0;
    repeat (3) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    rd_chk("temp", `ADDR_TEMP, 16'h0000);
    rd_chk("ident", `ADDR_IDENT, {8'h00, MAKER, REV});
    rd_chk("crit_lim", `ADDR_CRIT, 16'h4980);
    rd_chk("hyst", `ADDR_HYST, 16'h0005);
    rd_chk("high_lim", `ADDR_HIGH, 16'h2000);
    rd_chk("low_lim", `ADDR_LOW, 16'h0500);
    rd_chk("unmapped", 3'h0, 16'h0000);
    $display("test reset_values done");

    host_u.reg_write(`ADDR_TEMP, 16'h1234);
    host_u.reg_write(`ADDR_IDENT, 16'h00ff);
    host_u.reg_write(`ADDR_CRIT, 16'h1357);
    host_u.reg_write(`ADDR_HYST, 16'habcd);
    host_u.reg_write(`ADDR_HIGH, 16'h2468);
    host_u.reg_write(`ADDR_LOW, 16'hf00f);
    rd_chk("temp_ro", `ADDR_TEMP, 16'h0000);
    rd_chk("ident_ro", `ADDR_IDENT, {8'h00, MAKER, REV});
    rd_chk("crit_rw", `ADDR_CRIT, 16'h1357);
    rd_chk("hyst_rw", `ADDR_HYST, 16'h00cd);
    rd_chk("high_rw", `ADDR_HIGH, 16'h2468);
    rd_chk("low_rw", `ADDR_LOW, 16'hf00f);
    host_u.reg_write(`ADDR_CRIT, 16'h4980);
    host_u.reg_write(`ADDR_HYST, 16'h0005);
    host_u.reg_write(`ADDR_HIGH, 16'h2000);
    host_u.reg_write(`ADDR_LOW, 16'h0500);
    $display("test access done");

    conv(16'h4a07, 1'b1, 1'b1);
    rd_chk("flags", `ADDR_TEMP, 16'h4a06);
    conv(16'h4800, 1'b1, 1'b1);
    rd_chk("flag_hi", `ADDR_TEMP, 16'h4802);
    conv(16'h4600, 1'b0, 1'b1);
    conv(16'h1000, 1'b0, 1'b0);
    rd_chk("no_flag", `ADDR_TEMP, 16'h1000);
    conv(16'hff00, 1'b0, 1'b1);
    rd_chk("flag_lo", `ADDR_TEMP, 16'hff01);
    conv(16'h0600, 1'b0, 1'b1);
    conv(16'h0800, 1'b0, 1'b0);
    $display("test compare_13bit done");

    res16 = 1'b1;
    conv(16'h4a07, 1'b1, 1'b1);
    rd_chk("word16", `ADDR_TEMP, 16'h4a07);
    conv(16'h0005, 1'b0, 1'b1);
    rd_chk("word16_lo", `ADDR_TEMP, 16'h0005);
    conv(16'h1000, 1'b0, 1'b0);
    res16 = 1'b0;
    $display("test compare_16bit done");

    for (int q = 0; q < 4; q++)
    begin
      fq = 2'(q);
      repeat (q) conv(16'h3000, 1'b0, 1'b0);
      conv(16'h3000, 1'b0, 1'b1);
      conv(16'h1000, 1'b0, 1'b0);
    end
    fq = 2'h1;
    conv(16'h3000, 1'b0, 1'b0);
    conv(16'h1000, 1'b0, 1'b0);
    conv(16'h3000, 1'b0, 1'b0);
    conv(16'h3000, 1'b0, 1'b1);
    conv(16'h1000, 1'b0, 1'b0);
    fq = 2'h0;
    $display("test fault_queue done");

    // A pending event left from comparator mode is cleared first.
    cmp_mode = 1'b0;
    rd_chk("ident_int0", `ADDR_IDENT, {8'h00, MAKER, REV});
    check("int_idle", {15'h0, lim}, 16'h0000);
    conv(16'h3000, 1'b0, 1'b1);
    rd_chk("ident_int", `ADDR_IDENT, {8'h00, MAKER, REV});
    check("int_clear", {15'h0, lim}, 16'h0000);
    conv(16'h3000, 1'b0, 1'b0);
    conv(16'h1000, 1'b0, 1'b0);
    conv(16'h0100, 1'b0, 1'b1);
    rd_chk("temp_int", `ADDR_TEMP, 16'h0101);
    check("int_clear2", {15'h0, lim}, 16'h0000);
    $display("test interrupt_mode done");

    cmp_mode = 1'b1;
    host_u.reg_write(`ADDR_CRIT, 16'h1111);
    conv(16'h4a07, 1'b1, 1'b1);
    rst = 1'b1;
    repeat (3) @(negedge clk);
    rst = 1'b0;
    check("crit_rst", {15'h0, crit}, 16'h0000);
    check("limit_rst", {15'h0, lim}, 16'h0000);
    rd_chk("crit_lim_rst", `ADDR_CRIT, 16'h4980);
    rd_chk("temp_rst", `ADDR_TEMP, 16'h0000);
    $display("test mid_reset done");
    end_of_test;
  end
endmodule : tb
